// ### verif/codec_model.sv
// Codec model on the far side of the audio port
`timescale 1ns/1ns
module codec_model (
  input  wire        bclk,
  input  wire        sync,
  input  wire        dout,
  input  wire [15:0] word,
  output reg         din,
  output reg  [15:0] got
);
  reg [4:0] cnt = 5'h10;
  reg       sync_d = 1'b0;
  initial din = 1'b0;
  // Sync and clock may rise together; a repeated start is harmless
  always @(posedge bclk or posedge sync) begin
    if (sync && !sync_d) begin
      din = word[15];
    end else begin
      din = (cnt < 5'h10) ? word[15 - cnt] : ~din;
    end
  end
  // Frame start is seen again on the first falling edge, so one block owns cnt
  always @(negedge bclk) begin
    sync_d <= sync;
    if (sync && !sync_d) begin
      got <= {got[14:0], dout};
      cnt <= 5'h01;
    end else if (cnt < 5'h10) begin
      got <= {got[14:0], dout};
      cnt <= cnt + 5'h01;
    end
  end
endmodule // codec_model

// ### verif/pcm_port_assertions.sv
// Pin-level checks for the serial audio port
`timescale 1ns/1ns
module pcm_port_assertions (
  input wire        clock,
  input wire        sys_rst,
  input wire        clk_en,
  input wire        master_mode,
  input wire [1:0]  rate_sel,
  input wire [15:0] tx_sample,
  input wire        tx_taken,
  input wire [15:0] rx_sample,
  input wire        rx_valid,
  input wire        bclk_in,
  input wire        bclk_out,
  input wire        bclk_oe_n,
  input wire        sync_in,
  input wire        sync_out,
  input wire        sync_oe_n,
  input wire        data_out,
  input wire        data_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_oe_follow_mode: assert property (clk_en |=> bclk_oe_n == !$past(master_mode)
    && sync_oe_n == bclk_oe_n) else $error("drive enables do not follow mode");
  a_slave_quiet: assert property (!master_mode && !$past(master_mode)
    |-> !bclk_out && !sync_out) else $error("slave drives clock or sync");
  a_sync_on_rise: assert property ($changed(sync_out)
    |-> $past(bclk_out) && !$past(bclk_out, 2)) else $error("sync moved off bit clock rise");
  a_data_on_rise: assert property (master_mode && $changed(data_out)
    |-> $past(bclk_out) && !$past(bclk_out, 2)) else $error("data moved off bit clock rise");
  a_msb_at_sync: assert property ($rose(sync_out)
    |-> tx_taken && data_out == $past(tx_sample[15])) else $error("frame start without msb");
  a_taken_pulse: assert property (tx_taken |=> !tx_taken)
    else $error("sample taken longer than one cycle");
  a_valid_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("receive valid longer than one cycle");
  a_valid_clock_low: assert property (rx_valid && master_mode |-> !bclk_out)
    else $error("receive word not on falling half");
endmodule // pcm_port_assertions
////////////////////////////////////////
bind pcm_audio_serial_port pcm_port_assertions u_pcm_port_assertions (
  .clock       (clock),
  .sys_rst     (sys_rst),
  .clk_en      (clk_en),
  .master_mode (master_mode),
  .rate_sel    (rate_sel),
  .tx_sample   (tx_sample),
  .tx_taken    (tx_taken),
  .rx_sample   (rx_sample),
  .rx_valid    (rx_valid),
  .bclk_in     (bclk_in),
  .bclk_out    (bclk_out),
  .bclk_oe_n   (bclk_oe_n),
  .sync_in     (sync_in),
  .sync_out    (sync_out),
  .sync_oe_n   (sync_oe_n),
  .data_out    (data_out),
  .data_in     (data_in)
);

// ### verif/tb_top.sv
// Testbench for the serial audio port with a codec model
`timescale 1ns/1ns
module tb_top;
  reg         clock = 1'b0, sys_rst = 1'b1, master_mode = 1'b0, sbclk = 1'b0, ssync = 1'b0;
  reg  [1:0]  rate_sel = 2'h0;
  reg  [15:0] tx_sample = 16'hA5C3, cw = 16'h3C96, pw;
  wire [15:0] rx_sample, got;
  wire        tx_taken, rx_valid, bclk_out, bclk_oe_n, sync_out, sync_oe_n, data_out, data_in;
  wire        bclk_pin = bclk_oe_n ? sbclk : bclk_out;
  wire        sync_pin = sync_oe_n ? ssync : sync_out;
  integer     n_fail = 0, n_compared = 0, cc = 0, bc = 0, hc = 0, lc = 0, lb = 0, lh = 0;
  reg         bp = 1'b0, sp = 1'b0;
  initial forever #2 clock = ~clock;
  pcm_audio_serial_port u_pcm_audio_serial_port (.clock(clock), .sys_rst(sys_rst),
    .clk_en(1'b1), .master_mode(master_mode), .rate_sel(rate_sel), .tx_sample(tx_sample),
    .tx_taken(tx_taken), .rx_sample(rx_sample), .rx_valid(rx_valid), .bclk_in(bclk_pin),
    .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n), .sync_in(sync_pin), .sync_out(sync_out),
    .sync_oe_n(sync_oe_n), .data_out(data_out), .data_in(data_in));
  codec_model u_codec_model (.bclk(bclk_pin), .sync(sync_pin), .dout(data_out), .word(cw),
    .din(data_in), .got(got));
  ////////////////////////////////////////
  // Per-frame clock, bit clock and sync-high counts, latched at each sync rise
  always @(posedge clock) begin
    bp <= bclk_out;
    sp <= sync_out;
    if (sync_out && !sp) begin
      lc <= cc;
      lb <= bc;
      lh <= hc;
      cc <= 1;
      bc <= 0;
      hc <= 0;
    end else begin
      cc <= cc + 1;
      bc <= bc + (bclk_out && !bp);
      hc <= hc + (bclk_out && !bp && sync_out);
    end
  end
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task do_reset(input mm);
    begin
      sys_rst = 1'b1;
      master_mode = mm;
      repeat (20) @(posedge clock);
      #1 sys_rst = 1'b0;
    end
  endtask
  // Codec as clock master: one 32-bit frame, clock still outside it
  task slave_frame;
    integer i;
    begin
      @(posedge clock);
      #1;
      for (i = 0; i < 32; i = i + 1) begin
        sbclk = 1'b1;
        ssync = (i < 16);
        #32 sbclk = 1'b0;
        #32;
      end
      chk("slave enables", {bclk_oe_n, sync_oe_n}, 16'h0003);
      chk("slave word out", got, tx_sample);
      chk("slave word in", rx_sample, cw);
    end
  endtask
  task master_frame(input [1:0] nr, input [15:0] nw, input [6:0] nb);
    begin
      @(posedge sync_out);
      // Frame counts are latched one clock after the sync rise
      @(posedge clock);
      #1;
      chk("master enables", {bclk_oe_n, sync_oe_n}, 16'h0000);
      chk("bit clocks", lb[15:0], {9'h000, nb});
      chk("sync high", lh[15:0], {10'h000, nb[6:1]});
      chk("period ok", {15'h0000, lc >= 31249 && lc <= 31251}, 16'h0001);
      chk("word out", got, pw);
      chk("word in", rx_sample, cw);
      pw = tx_sample;
      rate_sel = nr;
      tx_sample = nw;
    end
  endtask
  initial begin
    do_reset(1'b0);
    slave_frame;
    // Code 3 is refused, so the first master frame keeps the reset rate
    rate_sel = 2'h3;
    do_reset(1'b1);
    @(posedge sync_out);
    #1;
    pw = tx_sample;
    rate_sel = 2'h1;
    tx_sample = 16'h8001;
    master_frame(2'h2, 16'h7FFE, 7'h20);
    master_frame(2'h3, 16'h0F0F, 7'h30);
    master_frame(2'h3, 16'hF0F0, 7'h40);
    conclude;
  end
  initial begin
    repeat (99000) @(posedge clock);
    n_fail = n_fail + 1;
    conclude;
  end
endmodule // tb_top

// ### verilog/pcm_audio_serial_port.v
// Full-duplex serial audio port, master or slave, 16-bit samples
//
// Contract
// R1 - Frame sync pulses once per frame, 8 kHz, 125 us period.
// R2 - Sync rising edge starts both outgoing and incoming sample together.
// R3 - All data bits shift and sample in step with the shared bit clock.
// R4 - Transmit and receive run together in the same frames, fixed directions.
// R5 - Outgoing samples leave on data out; incoming arrive on data in.
// R6 - Samples are 16-bit linear words, most significant bit first.
// R7 - Bit clock selectable 256, 384 or 512 kHz: 32, 48, 64 bits/frame.
// R8 - Master drives sync and bit clock; slave follows; sync high half frame.
`timescale 1ns/1ns
`include "pcm_port_map.vh"
module pcm_audio_serial_port (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        master_mode,
  input  wire [1:0]  rate_sel,
  input  wire [15:0] tx_sample,
  output reg         tx_taken,
  output reg  [15:0] rx_sample,
  output reg         rx_valid,
  input  wire        bclk_in,
  output reg         bclk_out,
  output reg         bclk_oe_n,
  input  wire        sync_in,
  output reg         sync_out,
  output reg         sync_oe_n,
  output reg         data_out,
  input  wire        data_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit clock, sync, data in
  wire [2:0] pin_level;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;

  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .pin     ({data_in, sync_in, bclk_in}),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  wire s_bclk_rise = pin_rise[0];
  wire s_bclk_fall = pin_fall[0];
  wire s_sync_rise = pin_rise[1];
  wire din         = pin_level[2];

  ////////////////////////////////////////////////////////////////////////////
  // Rate selection, taken only at a frame boundary
  reg  [1:0]          rate;
  reg  [`ACC_W-1:0]   inc;
  reg  [`CNT_W-1:0]   frame_bits;
  reg  [`CNT_W-1:0]   frame_last;
  reg  [`CNT_W-1:0]   half_bits;
  wire                rate_ok = (rate_sel == `RATE_256) || (rate_sel == `RATE_384) ||
                                (rate_sel == `RATE_512);

  always @* begin
    case (rate)
      `RATE_256: begin
        inc        = `ACC_INC_256; // R7
        frame_bits = `BITS_256;
      end
      `RATE_384: begin
        inc        = `ACC_INC_384; // R7
        frame_bits = `BITS_384;
      end
      default: begin
        inc        = `ACC_INC_512; // R7
        frame_bits = `BITS_512;
      end
    endcase
    frame_last = frame_bits - 7'h01;
    half_bits  = {1'b0, frame_bits[`CNT_W-1:1]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master bit clock: phase accumulator gives exact average rate, since
  // the system clock is no integer multiple of any bit clock; jitter is 4 ns
  reg  [`ACC_W-1:0] acc;
  reg               m_rise;
  reg               m_fall;
  wire [`ACC_W-1:0] acc_sum = acc + inc;
  wire              tick    = master_mode && (acc_sum >= `CLK_KHZ);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      acc      <= 19'h00000;
      bclk_out <= 1'b0;
      m_rise   <= 1'b0;
      m_fall   <= 1'b0;
    end else if (clk_en) begin
      m_rise <= tick & ~bclk_out;
      m_fall <= tick & bclk_out;
      if (!master_mode) begin
        acc      <= 19'h00000;
        bclk_out <= 1'b0;
      end else if (tick) begin
        acc      <= acc_sum - `CLK_KHZ;
        bclk_out <= ~bclk_out; // R8
      end else begin
        acc <= acc_sum;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common bit events from whichever side owns the bit clock
  reg  [`CNT_W-1:0] bit_cnt;
  wire bit_rise    = master_mode ? m_rise : s_bclk_rise; // R3
  wire bit_fall    = master_mode ? m_fall : s_bclk_fall; // R3
  // Slave frames start on the sync edge itself, taking priority over a rise
  wire frame_start = master_mode ? (m_rise && bit_cnt >= frame_last)
                                 : s_sync_rise; // R2

  ////////////////////////////////////////////////////////////////////////////
  // Role change drops a frame in flight so the new clock owner starts clean
  reg  mode_q;
  wire mode_flip = mode_q ^ master_mode;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= 1'b0;
    end else if (clk_en) begin
      mode_q <= master_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame counter, sync generation and pin direction
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rate      <= `RATE_256;
      bit_cnt   <= `CNT_MAX;
      sync_out  <= 1'b0;
      bclk_oe_n <= 1'b1;
      sync_oe_n <= 1'b1;
    end else if (clk_en) begin
      bclk_oe_n <= ~master_mode; // R8
      sync_oe_n <= ~master_mode; // R8
      if (!master_mode) begin
        sync_out <= 1'b0;
      end
      if (mode_flip) begin
        bit_cnt <= `CNT_MAX;
      end else if (frame_start) begin
        bit_cnt <= 7'h00;
        if (rate_ok) begin
          rate <= rate_sel; // R7
        end
        if (master_mode) begin
          sync_out <= 1'b1; // R1
        end
      end else if (bit_rise) begin
        if (bit_cnt != `CNT_MAX) begin
          bit_cnt <= bit_cnt + 7'h01;
        end
        if (master_mode) begin
          sync_out <= (bit_cnt + 7'h01) < half_bits; // R8
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter: MSB with the sync edge, zeros after the word
  reg [15:0] tx_shift;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_shift <= 16'h0000;
      data_out <= 1'b0;
      tx_taken <= 1'b0;
    end else if (clk_en) begin
      tx_taken <= frame_start;
      if (frame_start) begin
        data_out <= tx_sample[`SAMPLE_MSB]; // R6
        tx_shift <= {tx_sample[14:0], 1'b0}; // R2
      end else if (bit_rise) begin
        if (bit_cnt < (`SAMPLE_BITS - 1)) begin
          data_out <= tx_shift[`SAMPLE_MSB]; // R5
          tx_shift <= {tx_shift[14:0], 1'b0}; // R6
        end else begin
          data_out <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter runs beside transmit in the same frame
  reg [15:0] rx_shift;
  reg [4:0]  rx_idx;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift  <= 16'h0000;
      rx_idx    <= 5'h10;
      rx_sample <= 16'h0000;
      rx_valid  <= 1'b0;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      if (mode_flip) begin
        rx_idx <= 5'h10;
      end else if (frame_start) begin
        rx_idx <= 5'h00; // R2
      end else if (bit_fall && rx_idx < `SAMPLE_BITS) begin
        rx_shift <= {rx_shift[14:0], din}; // R4
        rx_idx   <= rx_idx + 5'h01;
        if (rx_idx == (`SAMPLE_BITS - 1)) begin
          rx_sample <= {rx_shift[14:0], din}; // R6
          rx_valid  <= 1'b1; // R5
        end
      end
    end
  end

endmodule // pcm_audio_serial_port

// ### verilog/pcm_port_map.vh
// Constants for the serial audio port: clock rates, frame layout, rate codes
`ifndef PCM_PORT_MAP_VH
`define PCM_PORT_MAP_VH

// System clock rate and frame rate
`define CLK_KHZ          19'h3D090
`define FRAME_KHZ        8
`define FRAME_US         125

// Sample word
`define SAMPLE_BITS      16
`define SAMPLE_MSB       15

// Bit clock rate codes
`define RATE_256         2'h0
`define RATE_384         2'h1
`define RATE_512         2'h2

// Bit clock rates in kHz
`define BCLK_KHZ_256     256
`define BCLK_KHZ_384     384
`define BCLK_KHZ_512     512

// Bit clock periods per frame, bit clock rate over frame rate
`define BITS_256         7'h20
`define BITS_384         7'h30
`define BITS_512         7'h40

// Accumulator step per clock, two toggles per bit clock period
`define ACC_INC_256      19'h00200
`define ACC_INC_384      19'h00300
`define ACC_INC_512      19'h00400

// Widths
`define ACC_W            19
`define CNT_W            7
`define CNT_MAX          7'h7F

`endif

// ### verilog/pin_sync.v
// Two-flop synchroniser with edge detection, one lane per pin
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 3
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] pin,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : lane
      reg stage1;
      reg stage2;
      reg stage3;
      // Stage1 feeds only stage2; edges come from the settled stages
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
        end else if (clk_en) begin
          stage1 <= pin[i];
          stage2 <= stage1;
          stage3 <= stage2;
        end
      end
      assign level[i] = stage2;
      assign rise[i]  = stage2 & ~stage3;
      assign fall[i]  = ~stage2 & stage3;
    end
  endgenerate

endmodule // pin_sync
